/* core/uart_rx_defs.svh */
// Purpose: constants for the serial receive path
// Assumes: oversampling by sixteen
// Notes: prescale ratios follow the clock_prescale_select code
`ifndef UART_RX_DEFS_SVH
`define UART_RX_DEFS_SVH
`define OVS_HALF_LAST   4'h7
`define OVS_FULL_LAST   4'hf
`define PRESCALE_DIV1   8'h00
`define PRESCALE_DIV8   8'h07
`define PRESCALE_DIV32  8'h1f
`define PRESCALE_DIV256 8'hff
`define BAUD_DIV_RESET  8'h00
`define DATA_LAST7      3'h6
`define DATA_LAST8      3'h7
`endif

/* core/uart_rx_pkg.sv */
// Purpose: types for the serial receive path
// Assumes: nothing beyond the defs header
// Notes: mode, mask and status travel as packed structs
package uart_rx_pkg;
   typedef struct packed {
      logic       uart_mode;
      logic       parity_en;
      logic       parity_odd;
      logic       stop_two;
      logic       char8;
      logic [1:0] clock_prescale_select;
      logic       clock_source_select;
   } mode_s;
   typedef struct packed {
      logic rx_done_request_select;
      logic rx_done_request_enable;
      logic rx_err_irq_enable;
      logic tx_empty_request_enable;
   } mask_s;
   typedef struct packed {
      logic rx_complete;
      logic overrun_flag;
      logic framing_error_flag;
      logic parity_error_flag;
      logic rx_error_sum;
      logic tx_complete;
   } status_s;
   typedef enum logic [4:0] {
      RX_IDLE   = 5'b00001,
      RX_START  = 5'b00010,
      RX_DATA   = 5'b00100,
      RX_PARITY = 5'b01000,
      RX_STOP   = 5'b10000
   } rx_state_e;
endpackage : uart_rx_pkg

/* core/uart_receive_path.sv */
// Purpose: asynchronous serial receiver with status and request outputs
// Assumes: rxd and ext_sclk are asynchronous pins; all other inputs are on clk
// Notes: rx_read reads buffer and status together and acknowledges the character
`timescale 1ns/100ps
`include "uart_rx_defs.svh"
module uart_receive_path (
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              rxd,
   input  wire logic              ext_sclk,
   input  wire logic              rx_enable,
   input  wire logic              rx_status_clear,
   input  wire uart_rx_pkg::mode_s mode,
   input  wire uart_rx_pkg::mask_s mask,
   input  wire logic [7:0]        baud_divisor,
   input  wire logic              rx_read,
   input  wire logic              tx_char_done,
   input  wire logic              tx_buf_empty,
   output logic [7:0]             rx_buf_r,
   output uart_rx_pkg::status_s   status_r,
   output logic                   rx_irq_r,
   output logic                   rx_dma_req_r,
   output logic                   rx_err_irq_r
);
   logic                   rxd_meta_r, rxd_sync_r, rxd_prev_r;
   logic                   sclk_meta_r, sclk_sync_r, sclk_prev_r;
   logic [7:0]             pre_cnt_r;
   logic [7:0]             pre_last;
   logic                   src_tick;
   logic [7:0]             baud_cnt_r;
   logic                   ovs_tick;
   logic [3:0]             ovs_cnt_r;
   logic [2:0]             bit_cnt_r;
   logic [7:0]             shift_r;
   logic                   par_acc_r;
   logic                   frame_err_r;
   logic                   par_err_r;
   logic                   stop2_pend_r;
   logic                   frame_end;
   logic                   frame_bad;
   logic                   start_edge;
   logic                   overrun_evt;
   logic                   frame_err_evt;
   logic                   par_err_evt;
   logic                   good_evt;
   uart_rx_pkg::rx_state_e state_r;

   // pin synchronisers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rxd_meta_r  <= 1'b1;
         rxd_sync_r  <= 1'b1;
         rxd_prev_r  <= 1'b1;
         sclk_meta_r <= 1'b0;
         sclk_sync_r <= 1'b0;
         sclk_prev_r <= 1'b0;
      end else begin
         rxd_meta_r  <= rxd;
         rxd_sync_r  <= rxd_meta_r;
         rxd_prev_r  <= rxd_sync_r;
         sclk_meta_r <= ext_sclk;
         sclk_sync_r <= sclk_meta_r;
         sclk_prev_r <= sclk_sync_r;
      end
   end

   // internal prescaler or external clock edge feeds the divisor
   always_comb begin
      unique case (mode.clock_prescale_select)
         2'b00: pre_last = `PRESCALE_DIV1;
         2'b01: pre_last = `PRESCALE_DIV8;
         2'b10: pre_last = `PRESCALE_DIV32;
         2'b11: pre_last = `PRESCALE_DIV256;
      endcase
   end

   assign src_tick = mode.clock_source_select ? (sclk_sync_r & ~sclk_prev_r)
                                              : (pre_cnt_r == pre_last);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pre_cnt_r <= 8'h00;
      end else if (pre_cnt_r >= pre_last) begin
         pre_cnt_r <= 8'h00;
      end else begin
         pre_cnt_r <= pre_cnt_r + 8'h01;
      end
   end

   assign ovs_tick = src_tick && (baud_cnt_r == `BAUD_DIV_RESET);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         baud_cnt_r <= `BAUD_DIV_RESET;
      end else if (src_tick) begin
         baud_cnt_r <= (baud_cnt_r == `BAUD_DIV_RESET) ? baud_divisor : baud_cnt_r - 8'h01;
      end
   end

   assign start_edge = rx_enable && mode.uart_mode && !rxd_sync_r && rxd_prev_r;

   // receive sequencer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r      <= uart_rx_pkg::RX_IDLE;
         ovs_cnt_r    <= 4'h0;
         bit_cnt_r    <= 3'h0;
         shift_r      <= 8'h00;
         par_acc_r    <= 1'b0;
         frame_err_r  <= 1'b0;
         par_err_r    <= 1'b0;
         stop2_pend_r <= 1'b0;
      end else if (!rx_enable) begin
         state_r <= uart_rx_pkg::RX_IDLE;
      end else begin
         unique case (state_r)
            uart_rx_pkg::RX_IDLE: begin
               if (start_edge) begin
                  state_r     <= uart_rx_pkg::RX_START;
                  ovs_cnt_r   <= 4'h0;
                  shift_r     <= 8'h00;
                  par_acc_r   <= mode.parity_odd;
                  frame_err_r <= 1'b0;
                  par_err_r   <= 1'b0;
               end
            end
            uart_rx_pkg::RX_START: begin
               if (rxd_sync_r) begin
                  state_r <= uart_rx_pkg::RX_IDLE;
               end else if (ovs_tick) begin
                  ovs_cnt_r <= ovs_cnt_r + 4'h1;
                  if (ovs_cnt_r == `OVS_HALF_LAST) begin
                     state_r   <= uart_rx_pkg::RX_DATA;
                     ovs_cnt_r <= 4'h0;
                     bit_cnt_r <= 3'h0;
                  end
               end
            end
            uart_rx_pkg::RX_DATA: begin
               if (ovs_tick) begin
                  ovs_cnt_r <= ovs_cnt_r + 4'h1;
                  if (ovs_cnt_r == `OVS_FULL_LAST) begin
                     shift_r   <= mode.char8 ? {rxd_sync_r, shift_r[7:1]}
                                             : {1'b0, rxd_sync_r, shift_r[6:1]};
                     par_acc_r <= par_acc_r ^ rxd_sync_r;
                     bit_cnt_r <= bit_cnt_r + 3'h1;
                     if (bit_cnt_r == (mode.char8 ? `DATA_LAST8 : `DATA_LAST7)) begin
                        state_r      <= mode.parity_en ? uart_rx_pkg::RX_PARITY : uart_rx_pkg::RX_STOP;
                        stop2_pend_r <= mode.stop_two;
                     end
                  end
               end
            end
            uart_rx_pkg::RX_PARITY: begin
               if (ovs_tick) begin
                  ovs_cnt_r <= ovs_cnt_r + 4'h1;
                  if (ovs_cnt_r == `OVS_FULL_LAST) begin
                     par_err_r <= par_acc_r ^ rxd_sync_r;
                     state_r   <= uart_rx_pkg::RX_STOP;
                  end
               end
            end
            uart_rx_pkg::RX_STOP: begin
               if (ovs_tick) begin
                  ovs_cnt_r <= ovs_cnt_r + 4'h1;
                  if (ovs_cnt_r == `OVS_FULL_LAST) begin
                     frame_err_r  <= frame_err_r | ~rxd_sync_r;
                     stop2_pend_r <= 1'b0;
                     if (!stop2_pend_r) begin
                        state_r <= uart_rx_pkg::RX_IDLE;
                     end
                  end
               end
            end
         endcase
      end
   end

   // last stop sample of the frame
   assign frame_end = rx_enable && (state_r == uart_rx_pkg::RX_STOP) && ovs_tick
                      && (ovs_cnt_r == `OVS_FULL_LAST) && !stop2_pend_r;
   assign frame_bad = par_err_r || frame_err_r || !rxd_sync_r;

   // receive buffer: loaded after any same-cycle read has seen the old value
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_buf_r <= 8'h00;
      end else if (frame_end) begin
         rx_buf_r <= shift_r;
      end
   end

   // frame-end events for status; good and overrun events also feed the requests
   assign overrun_evt   = frame_end && status_r.rx_complete && !rx_read;
   assign frame_err_evt = frame_end && (frame_err_r || !rxd_sync_r);
   assign par_err_evt   = frame_end && par_err_r;
   assign good_evt      = frame_end && !frame_bad && !overrun_evt;

   // status flags, one driver; setting wins over clearing
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         status_r.rx_complete        <= 1'b0;
         status_r.overrun_flag       <= 1'b0;
         status_r.framing_error_flag <= 1'b0;
         status_r.parity_error_flag  <= 1'b0;
         status_r.rx_error_sum       <= 1'b0;
         status_r.tx_complete        <= 1'b1;
      end else begin
         if (frame_end) begin
            status_r.rx_complete <= good_evt;
         end else if (rx_read || rx_status_clear) begin
            status_r.rx_complete <= 1'b0;
         end
         status_r.overrun_flag       <= overrun_evt | (status_r.overrun_flag & ~rx_status_clear);
         status_r.framing_error_flag <= frame_err_evt | (status_r.framing_error_flag & ~rx_status_clear);
         status_r.parity_error_flag  <= par_err_evt | (status_r.parity_error_flag & ~rx_status_clear);
         status_r.rx_error_sum <= overrun_evt | frame_err_evt | par_err_evt
                                  | ((status_r.overrun_flag | status_r.framing_error_flag
                                  | status_r.parity_error_flag) & ~rx_status_clear);
         // transmit complete only once the buffer has run dry
         if (tx_char_done && tx_buf_empty) begin
            status_r.tx_complete <= 1'b1;
         end else if (!tx_buf_empty) begin
            status_r.tx_complete <= 1'b0;
         end
      end
   end

   // completion and error requests, one-cycle pulses
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_irq_r     <= 1'b0;
         rx_dma_req_r <= 1'b0;
         rx_err_irq_r <= 1'b0;
      end else begin
         rx_irq_r     <= good_evt && mask.rx_done_request_enable && !mask.rx_done_request_select;
         rx_dma_req_r <= good_evt && mask.rx_done_request_enable && mask.rx_done_request_select;
         rx_err_irq_r <= frame_end && (frame_bad || overrun_evt) && mask.rx_err_irq_enable;
      end
   end
endmodule : uart_receive_path

/* verification/uart_rx_assertions.sv */
// Purpose: port checks for the serial receive path
// Assumes: single clk domain
// Notes: bound from the testbench file
`timescale 1ns/100ps
module uart_rx_assertions (
   input wire logic                 clk,
   input wire logic                 resetn,
   input wire uart_rx_pkg::mask_s   mask,
   input wire logic                 tx_char_done,
   input wire logic                 tx_buf_empty,
   input wire uart_rx_pkg::status_s status_r,
   input wire logic                 rx_irq_r,
   input wire logic                 rx_dma_req_r,
   input wire logic                 rx_err_irq_r
);
   logic err_any;
   assign err_any = status_r.overrun_flag | status_r.framing_error_flag | status_r.parity_error_flag;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   AST_SUM: assert property (status_r.rx_error_sum == err_any)
      else $error("error summary differs from flags");
   AST_IRQ_SEL: assert property (rx_irq_r |-> mask.rx_done_request_enable && !mask.rx_done_request_select)
      else $error("completion interrupt with wrong select");
   AST_DMA_SEL: assert property (rx_dma_req_r |-> mask.rx_done_request_enable && mask.rx_done_request_select)
      else $error("dma request with wrong select");
   AST_DONE: assert property ((rx_irq_r || rx_dma_req_r) |-> status_r.rx_complete)
      else $error("completion request without complete bit");
   AST_ERR_IRQ: assert property (rx_err_irq_r |-> mask.rx_err_irq_enable && status_r.rx_error_sum && !rx_irq_r)
      else $error("error interrupt not justified");
   AST_OVR: assert property ($rose(status_r.overrun_flag) |-> !status_r.rx_complete)
      else $error("overrun left complete set");
   AST_FE: assert property ($rose(status_r.framing_error_flag) |-> !$rose(status_r.rx_complete))
      else $error("erroneous character set complete");
   AST_TXC: assert property (tx_char_done && !tx_buf_empty |=> !status_r.tx_complete)
      else $error("transmit complete set mid run");
   AST_PULSE: assert property (rx_irq_r |=> !rx_irq_r)
      else $error("completion interrupt longer than one cycle");
endmodule : uart_rx_assertions

/* verification/serial_tx_model.sv */
// Purpose: remote serial transmitter on the receive pin
// Assumes: bit time given in clk cycles
// Notes: line idles high, changes on falling clk
`timescale 1ns/100ps
module serial_tx_model #(
   parameter int BIT = 32
) (
   input wire logic clk,
   output logic     rxd
);
   int bit_len = BIT;
   initial rxd = 1'b1;
   // low start, n bits lsb first, ns stops at level sl
   task send(input logic [8:0] b, input int n, input int ns, input logic sl);
      rxd = 1'b0;
      repeat (bit_len) @(negedge clk);
      for (int i = 0; i < n; i++) begin
         rxd = b[i];
         repeat (bit_len) @(negedge clk);
      end
      for (int i = 0; i < ns; i++) begin
         rxd = sl;
         repeat (bit_len) @(negedge clk);
      end
      rxd = 1'b1;
   endtask : send
   task glitch();
      rxd = 1'b0;
      repeat (BIT / 5) @(negedge clk);
      rxd = 1'b1;
      repeat (BIT * 12) @(negedge clk);
   endtask : glitch
endmodule : serial_tx_model

/* verification/testbench.sv */
// Purpose: self-checking bench for the serial receive path
// Assumes: 32 clk per bit unless a scenario sets another rate
// Notes: status compared whole as a 6-bit value
`timescale 1ns/100ps
module testbench;
   logic                 clk;
   logic                 resetn;
   logic                 rx_enable;
   logic                 rx_status_clear;
   logic                 rx_read;
   logic                 tx_char_done;
   logic                 tx_buf_empty;
   logic                 rxd;
   logic                 ext_sclk;
   logic [7:0]           baud_div;
   logic [7:0]           rx_buf_r;
   uart_rx_pkg::mode_s   mode;
   uart_rx_pkg::mask_s   mask;
   uart_rx_pkg::status_s status_r;
   logic                 rx_irq_r;
   logic                 rx_dma_req_r;
   logic                 rx_err_irq_r;
   int                   err_count;
   int                   n_compared;
   int                   n_irq;
   int                   n_dma;
   int                   n_err;
   serial_tx_model #(.BIT(32)) peer (.clk(clk), .rxd(rxd));
   uart_receive_path DUT (.clk(clk), .resetn(resetn), .rxd(rxd), .ext_sclk(ext_sclk), .rx_enable(rx_enable),
      .rx_status_clear(rx_status_clear), .mode(mode), .mask(mask), .baud_divisor(baud_div), .rx_read(rx_read),
      .tx_char_done(tx_char_done), .tx_buf_empty(tx_buf_empty), .rx_buf_r(rx_buf_r), .status_r(status_r),
      .rx_irq_r(rx_irq_r), .rx_dma_req_r(rx_dma_req_r), .rx_err_irq_r(rx_err_irq_r));
   // external source clock, one rising edge every two clk
   always @(negedge clk) begin
      ext_sclk <= ~ext_sclk;
   end
   always @(posedge clk) begin
      n_irq <= n_irq + int'(rx_irq_r);
      n_dma <= n_dma + int'(rx_dma_req_r);
      n_err <= n_err + int'(rx_err_irq_r);
   end
   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         err_count++;
      end
   endtask : check
   task final_report();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report
   // mode change only with reception off
   task cfg(input logic [7:0] m, input logic [3:0] k, input logic [7:0] d);
      rx_enable = 1'b0;
      mode = m;
      mask = k;
      baud_div = d;
      rx_status_clear = 1'b1;
      @(negedge clk);
      rx_status_clear = 1'b0;
      rx_enable = 1'b1;
      n_irq = 0;
      n_dma = 0;
      n_err = 0;
   endtask : cfg
   task rd();
      rx_read = 1'b1;
      @(negedge clk);
      rx_read = 1'b0;
   endtask : rd
   task frame(input logic [8:0] b, input int n, input int ns, input logic sl);
      peer.send(b, n, ns, sl);
      repeat (4) @(negedge clk);
   endtask : frame
   task t_clean();
      cfg(8'h88, 4'b0110, 8'h01);
      frame(9'h0a5, 8, 1, 1'b1);
      check(rx_buf_r, 8'ha5);
      check(8'(status_r), 8'h21);
      check(8'(n_irq), 8'h01);
      check(8'(n_dma), 8'h00);
      rd();
      check(8'(status_r), 8'h01);
   endtask : t_clean
   task t_dma_odd();
      cfg(8'he0, 4'b1110, 8'h01);
      frame(9'h0da, 8, 1, 1'b1);
      check(rx_buf_r, 8'h5a);
      check(8'(n_dma), 8'h01);
      check(8'(n_irq), 8'h00);
      rd();
   endtask : t_dma_odd
   task t_parity_two_stop();
      cfg(8'hd0, 4'b1110, 8'h01);
      frame(9'h0da, 8, 2, 1'b1);
      check(8'(status_r), 8'h07);
      check(8'(n_dma), 8'h00);
      check(8'(n_err), 8'h01);
   endtask : t_parity_two_stop
   task t_framing();
      cfg(8'h88, 4'b0100, 8'h01);
      frame(9'h033, 8, 1, 1'b0);
      check(8'(status_r), 8'h0b);
      check(8'(n_err + n_irq), 8'h00);
   endtask : t_framing
   task t_overrun();
      cfg(8'h88, 4'b0110, 8'h01);
      frame(9'h011, 8, 1, 1'b1);
      frame(9'h022, 8, 1, 1'b1);
      check(rx_buf_r, 8'h22);
      check(8'(status_r), 8'h13);
      check(8'(n_irq), 8'h01);
      check(8'(n_err), 8'h01);
   endtask : t_overrun
   task t_noise_disable();
      cfg(8'h88, 4'b0110, 8'h01);
      peer.glitch();
      rx_enable = 1'b0;
      frame(9'h055, 8, 1, 1'b1);
      rx_enable = 1'b1;
      check(8'(status_r), 8'h01);
      frame(9'h03c, 8, 1, 1'b1);
      check(rx_buf_r, 8'h3c);
      rd();
   endtask : t_noise_disable
   // external clock, then prescale by eight, divisor 0
   task t_rate();
      cfg(8'h89, 4'b0000, 8'h00);
      frame(9'h0c3, 8, 1, 1'b1);
      check(rx_buf_r, 8'hc3);
      rd();
      cfg(8'h8a, 4'b0000, 8'h00);
      peer.bit_len = 128;
      frame(9'h096, 8, 1, 1'b1);
      peer.bit_len = 32;
      check(rx_buf_r, 8'h96);
      check(8'(status_r), 8'h21);
      rd();
   endtask : t_rate
   task t_tx_run();
      mask = 4'b0001;
      tx_buf_empty = 1'b0;
      tx_char_done = 1'b1;
      @(negedge clk);
      tx_char_done = 1'b0;
      @(negedge clk);
      check(8'(status_r), 8'h00);
      tx_buf_empty = 1'b1;
      tx_char_done = 1'b1;
      @(negedge clk);
      tx_char_done = 1'b0;
      @(negedge clk);
      check(8'(status_r), 8'h01);
   endtask : t_tx_run
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      resetn = 1'b0;
      rx_enable = 1'b0;
      rx_status_clear = 1'b0;
      rx_read = 1'b0;
      tx_char_done = 1'b0;
      tx_buf_empty = 1'b1;
      ext_sclk = 1'b0;
      baud_div = 8'h01;
      mode = 8'h88;
      mask = 4'h0;
      err_count = 0;
      n_compared = 0;
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      check(rx_buf_r, 8'h00);
      check(8'(status_r), 8'h01);
      t_clean();
      t_dma_odd();
      t_parity_two_stop();
      t_framing();
      t_overrun();
      t_noise_disable();
      t_rate();
      t_tx_run();
      final_report();
   end
endmodule : testbench
bind uart_receive_path uart_rx_assertions chk (.clk(clk), .resetn(resetn), .mask(mask),
   .tx_char_done(tx_char_done), .tx_buf_empty(tx_buf_empty), .status_r(status_r), .rx_irq_r(rx_irq_r),
   .rx_dma_req_r(rx_dma_req_r), .rx_err_irq_r(rx_err_irq_r));
